// ---- hdl/rxt_pkg.sv ----
/*
  rxt_pkg: register indices, field positions, reset values and masks for the
  crystal trim, signal strength and rate acceptance register bank.
  Assumes a 32-bit Avalon-MM slave with byte addresses; each register sits in
  the low byte of one aligned word at byte address four times its index.
*/
// Functional notes
// - four trim bits connect 500/250/125 fF capacitors
// - bit 0 enables strength pin buffer, resets on
// - source select: strength, temperature, half digital supply
// - offset equals twice code minus 256
// - slope multiplier equals code times 2^-7
// - upper threshold widens upward rate tolerance
// - lower threshold widens downward rate tolerance
// - thresholds act only when rate limit enabled
package rxt_pkg;

  // ****************************************************************
  // register indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [9:0] IDX_CRYSTAL_FINE_TRIM   = 10'h08d;
  localparam logic [9:0] IDX_STRENGTH_PIN_CONFIG = 10'h08e;
  localparam logic [9:0] IDX_CONVERTER_SOURCE    = 10'h08f;
  localparam logic [9:0] IDX_STRENGTH_OFFSET     = 10'h090;
  localparam logic [9:0] IDX_STRENGTH_SLOPE      = 10'h091;
  localparam logic [9:0] IDX_RATE_UPPER          = 10'h092;
  localparam logic [9:0] IDX_RATE_LOWER          = 10'h093;
  localparam logic [9:0] IDX_RECOVERY_CONFIG     = 10'h0a0;
  localparam logic [9:0] IDX_STRENGTH_RESULT     = 10'h0a1;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TRIM_500FF_BIT   = 3;
  localparam int TRIM_250FF_BIT   = 2;
  localparam int TRIM_125FF_BIT   = 1;
  localparam int TRIM_SMALL_BIT   = 0;
  localparam int PIN_BUF_EN_BIT   = 0;
  localparam int RATE_LIM_EN_BIT  = 0;

  // ****************************************************************
  // writable masks and reset values
  // ****************************************************************
  localparam logic [7:0] MASK_CRYSTAL_FINE_TRIM   = 8'h0f;
  localparam logic [7:0] MASK_STRENGTH_PIN_CONFIG = 8'h01;
  localparam logic [7:0] MASK_CONVERTER_SOURCE    = 8'h07;
  localparam logic [7:0] MASK_RECOVERY_CONFIG     = 8'h01;

  localparam logic [7:0] RST_CRYSTAL_FINE_TRIM   = 8'h00;
  localparam logic [7:0] RST_STRENGTH_PIN_CONFIG = 8'h01;
  localparam logic [7:0] RST_CONVERTER_SOURCE    = 8'h00;
  localparam logic [7:0] RST_STRENGTH_OFFSET     = 8'h80;
  localparam logic [7:0] RST_STRENGTH_SLOPE      = 8'h80;
  localparam logic [7:0] RST_RATE_UPPER          = 8'h1e;
  localparam logic [7:0] RST_RATE_LOWER          = 8'h23;
  localparam logic [7:0] RST_RECOVERY_CONFIG     = 8'h00;

  // ****************************************************************
  // strength compensation constants
  // ****************************************************************
  localparam logic [9:0] STRENGTH_OFFSET_BIAS  = 10'h100;
  localparam int         STRENGTH_SLOPE_SHIFT  = 7;

  // ****************************************************************
  // converter sources
  // ****************************************************************
  typedef enum logic [2:0] {
    RXT_SRC_STRENGTH    = 3'b000,
    RXT_SRC_TEMPERATURE = 3'b001,
    RXT_SRC_HALF_SUPPLY = 3'b010
  } rxt_source_t;

endpackage : rxt_pkg

// ---- hdl/rxt_regs.sv ----
/*
  rxt_regs: crystal fine trim, strength pin buffer, converter source select,
  signal strength compensation and rate acceptance register bank behind an
  Avalon-MM slave with waitrequest.
  Assumes all inputs are on clk; srst is synchronous and active high.
*/
`timescale 1ns/10ps
module rxt_regs
  import rxt_pkg::*;
#(
  parameter int RAW_W = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [11:0]      avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic [RAW_W-1:0] strength_raw,
  input  wire logic [7:0]       rate_dev_up,
  input  wire logic [7:0]       rate_dev_down,
  output logic                  trim_cap_500ff_switch,
  output logic                  trim_cap_250ff_switch,
  output logic                  trim_cap_125ff_switch,
  output logic                  trim_cap_smallest_switch,
  output logic                  strength_pin_buffer_enable,
  output logic      [2:0]       converter_source_select,
  output logic                  route_strength,
  output logic                  route_temperature,
  output logic                  route_half_supply,
  output logic      [RAW_W-1:0] strength_comp,
  output logic                  rate_limit_enable,
  output logic      [7:0]       rate_upper_threshold,
  output logic      [7:0]       rate_lower_threshold,
  output logic                  rate_accept
);

  if (RAW_W < 8 || RAW_W > 16) begin : g_raw_w_check
    $error("rxt_regs: RAW_W must be 8 to 16");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] masked_write(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    masked_write = data & mask;
  endfunction : masked_write

  function automatic logic hits(
    input logic [9:0] idx,
    input logic [9:0] target
  );
    hits = (idx == target);
  endfunction : hits

  // ****************************************************************
  // bus handshake: one wait cycle per request
  // ****************************************************************
  logic       ack_r;
  logic       req;
  logic       wr_commit;
  logic       rd_capture;
  logic [9:0] reg_idx;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign reg_idx         = avs_address[11:2];
  assign wr_commit       = avs_write & ack_r & avs_byteenable[0];
  assign rd_capture      = avs_read & ~ack_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ****************************************************************
  // crystal fine trim
  // ****************************************************************
  logic [7:0] crystal_fine_trim_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      crystal_fine_trim_r <= RST_CRYSTAL_FINE_TRIM;
    end else if (wr_commit && hits(reg_idx, IDX_CRYSTAL_FINE_TRIM)) begin
      crystal_fine_trim_r <= masked_write(avs_writedata[7:0],
                                          MASK_CRYSTAL_FINE_TRIM);
    end
  end

  assign trim_cap_500ff_switch    = crystal_fine_trim_r[TRIM_500FF_BIT];
  assign trim_cap_250ff_switch    = crystal_fine_trim_r[TRIM_250FF_BIT];
  assign trim_cap_125ff_switch    = crystal_fine_trim_r[TRIM_125FF_BIT];
  assign trim_cap_smallest_switch = crystal_fine_trim_r[TRIM_SMALL_BIT];

  // ****************************************************************
  // strength pin buffer
  // ****************************************************************
  logic [7:0] strength_pin_config_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      strength_pin_config_r <= RST_STRENGTH_PIN_CONFIG;
    end else if (wr_commit && hits(reg_idx, IDX_STRENGTH_PIN_CONFIG)) begin
      strength_pin_config_r <= masked_write(avs_writedata[7:0],
                                            MASK_STRENGTH_PIN_CONFIG);
    end
  end

  assign strength_pin_buffer_enable = strength_pin_config_r[PIN_BUF_EN_BIT];

  // ****************************************************************
  // converter source select
  // ****************************************************************
  logic [7:0] converter_source_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      converter_source_r <= RST_CONVERTER_SOURCE;
    end else if (wr_commit && hits(reg_idx, IDX_CONVERTER_SOURCE)) begin
      converter_source_r <= masked_write(avs_writedata[7:0],
                                         MASK_CONVERTER_SOURCE);
    end
  end

  assign converter_source_select = converter_source_r[2:0];

  always_comb begin
    route_strength    = 1'b0;
    route_temperature = 1'b0;
    route_half_supply = 1'b0;
    case (converter_source_r[2:0])
      RXT_SRC_STRENGTH: begin
        route_strength = 1'b1;
      end
      RXT_SRC_TEMPERATURE: begin
        route_temperature = 1'b1;
      end
      RXT_SRC_HALF_SUPPLY: begin
        route_half_supply = 1'b1;
      end
      default: begin
        route_strength = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // strength offset and slope
  // ****************************************************************
  logic [7:0] strength_offset_r;
  logic [7:0] strength_slope_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      strength_offset_r <= RST_STRENGTH_OFFSET;
    end else if (wr_commit && hits(reg_idx, IDX_STRENGTH_OFFSET)) begin
      strength_offset_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strength_slope_r <= RST_STRENGTH_SLOPE;
    end else if (wr_commit && hits(reg_idx, IDX_STRENGTH_SLOPE)) begin
      strength_slope_r <= avs_writedata[7:0];
    end
  end

  rxt_strength_comp #(
    .RAW_W                (RAW_W)
  ) u_comp (
    .clk                  (clk),
    .srst                 (srst),
    .strength_raw         (strength_raw),
    .strength_offset_code (strength_offset_r),
    .strength_slope_code  (strength_slope_r),
    .strength_comp        (strength_comp)
  );

  // ****************************************************************
  // rate acceptance thresholds
  // ****************************************************************
  logic [7:0] rate_upper_r;
  logic [7:0] rate_lower_r;
  logic [7:0] recovery_config_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      rate_upper_r <= RST_RATE_UPPER;
    end else if (wr_commit && hits(reg_idx, IDX_RATE_UPPER)) begin
      rate_upper_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rate_lower_r <= RST_RATE_LOWER;
    end else if (wr_commit && hits(reg_idx, IDX_RATE_LOWER)) begin
      rate_lower_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      recovery_config_r <= RST_RECOVERY_CONFIG;
    end else if (wr_commit && hits(reg_idx, IDX_RECOVERY_CONFIG)) begin
      recovery_config_r <= masked_write(avs_writedata[7:0],
                                        MASK_RECOVERY_CONFIG);
    end
  end

  assign rate_limit_enable    = recovery_config_r[RATE_LIM_EN_BIT];
  assign rate_upper_threshold = rate_upper_r;
  assign rate_lower_threshold = rate_lower_r;

  // ****************************************************************
  // rate acceptance decision
  // ****************************************************************
  logic rate_up_ok;
  logic rate_down_ok;
  logic rate_accept_nxt;
  logic rate_accept_r;

  assign rate_up_ok      = (rate_dev_up <= rate_upper_r);
  assign rate_down_ok    = (rate_dev_down <= rate_lower_r);
  assign rate_accept_nxt = ~rate_limit_enable | (rate_up_ok & rate_down_ok);

  always_ff @(posedge clk) begin
    if (srst) begin
      rate_accept_r <= 1'b1;
    end else begin
      rate_accept_r <= rate_accept_nxt;
    end
  end

  assign rate_accept = rate_accept_r;

  // ****************************************************************
  // read back
  // ****************************************************************
  function automatic logic [7:0] read_mux(
    input logic [9:0]       idx,
    input logic [RAW_W-1:0] comp
  );
    logic [7:0] val;
    val = 8'h00;
    case (idx)
      IDX_CRYSTAL_FINE_TRIM:   val = crystal_fine_trim_r;
      IDX_STRENGTH_PIN_CONFIG: val = strength_pin_config_r;
      IDX_CONVERTER_SOURCE:    val = converter_source_r;
      IDX_STRENGTH_OFFSET:     val = strength_offset_r;
      IDX_STRENGTH_SLOPE:      val = strength_slope_r;
      IDX_RATE_UPPER:          val = rate_upper_r;
      IDX_RATE_LOWER:          val = rate_lower_r;
      IDX_RECOVERY_CONFIG:     val = recovery_config_r;
      IDX_STRENGTH_RESULT:     val = comp[RAW_W-1:RAW_W-8];
      default:                 val = 8'h00;
    endcase
    read_mux = val;
  endfunction : read_mux

  logic [31:0] readdata_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      readdata_r <= 32'h0000_0000;
    end else if (rd_capture) begin
      readdata_r <= {24'h00_0000, read_mux(reg_idx, strength_comp)};
    end
  end

  assign avs_readdata = readdata_r;

endmodule : rxt_regs

// ---- hdl/rxt_strength_comp.sv ----
/*
  rxt_strength_comp: scales the raw digital signal strength by the slope code
  and adds twice the offset code minus 256, saturating into the raw range; registered output.
  Assumes raw value, slope and offset codes all on clk.
*/
`timescale 1ns/10ps
module rxt_strength_comp
  import rxt_pkg::*;
#(
  parameter int RAW_W = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [RAW_W-1:0] strength_raw,
  input  wire logic [7:0]       strength_offset_code,
  input  wire logic [7:0]       strength_slope_code,
  output logic      [RAW_W-1:0] strength_comp
);

  localparam int SUM_W = RAW_W + 3;

  if (RAW_W < 8 || RAW_W > 16) begin : g_raw_w_check
    $error("rxt_strength_comp: RAW_W must be 8 to 16");
  end

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  logic [RAW_W+7:0] product;
  logic [RAW_W+7:0] shifted;
  logic [RAW_W:0]   scaled;
  logic [9:0]       offset_val;
  logic [SUM_W-1:0] sum;
  logic [RAW_W-1:0] comp_nxt;

  assign product    = {8'h00, strength_raw} * {{RAW_W{1'b0}}, strength_slope_code};
  assign shifted    = product >> STRENGTH_SLOPE_SHIFT;
  assign scaled     = shifted[RAW_W:0];
  assign offset_val = {1'b0, strength_offset_code, 1'b0} - STRENGTH_OFFSET_BIAS;
  assign sum        = {2'b00, scaled} + {{(SUM_W-10){offset_val[9]}}, offset_val};

  always_comb begin
    if (sum[SUM_W-1]) begin
      comp_nxt = '0;
    end else if (|sum[SUM_W-2:RAW_W]) begin
      comp_nxt = '1;
    end else begin
      comp_nxt = sum[RAW_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strength_comp <= '0;
    end else begin
      strength_comp <= comp_nxt;
    end
  end

endmodule : rxt_strength_comp

// ---- testbench/rxt_regs_monitor.sv ----
/*
  rxt_regs_monitor: concurrent checks on the register bank ports.
  Assumes it is bound to rxt_regs, one clock, srst synchronous active high.
*/
`timescale 1ns/10ps
module rxt_regs_monitor
  import rxt_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  rate_dev_up,
  input wire logic [7:0]  rate_dev_down,
  input wire logic        trim_cap_500ff_switch,
  input wire logic        trim_cap_250ff_switch,
  input wire logic        trim_cap_125ff_switch,
  input wire logic        trim_cap_smallest_switch,
  input wire logic        strength_pin_buffer_enable,
  input wire logic [2:0]  converter_source_select,
  input wire logic        route_strength,
  input wire logic        route_temperature,
  input wire logic        route_half_supply,
  input wire logic        rate_limit_enable,
  input wire logic [7:0]  rate_upper_threshold,
  input wire logic [7:0]  rate_lower_threshold,
  input wire logic        rate_accept
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (srst);

  // ****************************************
  // bus steps
  // ****************************************
  sequence req_open;
    $rose(avs_read || avs_write);
  endsequence
  sequence wr_to(logic [9:0] i);
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[11:2] == i;
  endsequence

  // ****************************************
  // checks
  // ****************************************
  chk_wait_first: assert property (req_open |-> avs_waitrequest)
    else $error("waitrequest low on a new request");
  chk_wait_single: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held beyond one cycle");
  chk_read_upper: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  chk_trim_write: assert property (
    wr_to(IDX_CRYSTAL_FINE_TRIM) |=> {trim_cap_500ff_switch, trim_cap_250ff_switch,
    trim_cap_125ff_switch, trim_cap_smallest_switch} == $past(avs_writedata[3:0]))
    else $error("trim switches differ from written value");
  chk_pin_write: assert property (wr_to(IDX_STRENGTH_PIN_CONFIG) |=>
    strength_pin_buffer_enable == $past(avs_writedata[0]))
    else $error("pin buffer enable differs from written value");
  chk_src_route: assert property (
    route_strength == (converter_source_select == 3'b000) &&
    route_temperature == (converter_source_select == 3'b001) &&
    route_half_supply == (converter_source_select == 3'b010))
    else $error("source route decode wrong");
  chk_upper_write: assert property (
    wr_to(IDX_RATE_UPPER) |=> rate_upper_threshold == $past(avs_writedata[7:0]))
    else $error("upper threshold differs from written value");
  chk_lower_write: assert property (
    wr_to(IDX_RATE_LOWER) |=> rate_lower_threshold == $past(avs_writedata[7:0]))
    else $error("lower threshold differs from written value");
  chk_accept_off: assert property (!rate_limit_enable |=> rate_accept)
    else $error("rate refused while limit disabled");
  chk_accept_cmp: assert property (rate_limit_enable |=> rate_accept ==
    ($past(rate_dev_up) <= $past(rate_upper_threshold) &&
    $past(rate_dev_down) <= $past(rate_lower_threshold)))
    else $error("rate acceptance compare wrong");
endmodule : rxt_regs_monitor

bind rxt_regs rxt_regs_monitor mon (.clk(clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rate_dev_up(rate_dev_up), .rate_dev_down(rate_dev_down),
  .trim_cap_500ff_switch(trim_cap_500ff_switch), .trim_cap_250ff_switch(trim_cap_250ff_switch),
  .trim_cap_125ff_switch(trim_cap_125ff_switch), .trim_cap_smallest_switch(trim_cap_smallest_switch),
  .strength_pin_buffer_enable(strength_pin_buffer_enable),
  .converter_source_select(converter_source_select), .route_strength(route_strength),
  .route_temperature(route_temperature), .route_half_supply(route_half_supply),
  .rate_limit_enable(rate_limit_enable), .rate_upper_threshold(rate_upper_threshold),
  .rate_lower_threshold(rate_lower_threshold), .rate_accept(rate_accept));

// ---- testbench/rxt_regs_test.sv ----
/*
  rxt_regs_test: self-checking bench for the register bank.
  Assumes an Avalon-MM slave with waitrequest; 125 MHz clock.
*/
`timescale 1ns/10ps
module rxt_regs_test
  import rxt_pkg::*;
;
  logic        clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [3:0]  avs_byteenable;
  logic [7:0]  strength_raw, strength_comp, rate_dev_up, rate_dev_down, rate_upper_threshold;
  logic [7:0]  rate_lower_threshold;
  logic [2:0]  converter_source_select;
  logic        t500, t250, t125, tsm, pin_en, r_str, r_tmp, r_half, lim_en, rate_accept;
  int          err_total, n_tests;
  logic [9:0]  ridx [8] = '{IDX_CRYSTAL_FINE_TRIM, IDX_STRENGTH_PIN_CONFIG, IDX_CONVERTER_SOURCE,
    IDX_STRENGTH_OFFSET, IDX_STRENGTH_SLOPE, IDX_RATE_UPPER, IDX_RATE_LOWER, IDX_RECOVERY_CONFIG};
  logic [7:0]  rval [8] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h80, 8'h1e, 8'h23, 8'h00};
  logic [7:0]  rmsk [8] = '{8'h0f, 8'h01, 8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01};
  logic [7:0]  c_raw [6] = '{8'h64, 8'hc8, 8'h64, 8'h0a, 8'h64, 8'h32};
  logic [7:0]  c_slp [6] = '{8'h80, 8'hff, 8'h80, 8'h40, 8'h60, 8'h00};
  logic [7:0]  c_off [6] = '{8'h80, 8'h80, 8'h00, 8'hff, 8'h85, 8'h81};

  rxt_regs #(.RAW_W(8)) dut (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .strength_raw(strength_raw), .rate_dev_up(rate_dev_up),
    .rate_dev_down(rate_dev_down), .trim_cap_500ff_switch(t500), .trim_cap_250ff_switch(t250),
    .trim_cap_125ff_switch(t125), .trim_cap_smallest_switch(tsm),
    .strength_pin_buffer_enable(pin_en), .converter_source_select(converter_source_select),
    .route_strength(r_str), .route_temperature(r_tmp), .route_half_supply(r_half),
    .strength_comp(strength_comp), .rate_limit_enable(lim_en),
    .rate_upper_threshold(rate_upper_threshold), .rate_lower_threshold(rate_lower_threshold),
    .rate_accept(rate_accept));

  always #4 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, 4'h1, x);
  endtask : wr

  task automatic rchk(input string nm, input logic [9:0] idx, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, 4'h0, x);
    chk(nm, {24'h00_0000, e}, x);
  endtask : rchk

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic rate_case(input logic en, input logic [7:0] up, input logic [7:0] dn,
                           input logic e);
    wr(IDX_RECOVERY_CONFIG, {7'h00, en});
    rate_dev_up <= up;
    rate_dev_down <= dn;
    settle();
    chk("rate_limit_enable", {31'h0000_0000, en}, {31'h0000_0000, lim_en});
    chk("rate_accept", {31'h0000_0000, e}, {31'h0000_0000, rate_accept});
  endtask : rate_case

  function automatic logic [7:0] comp_exp(input int r, input int s, input int o);
    int x;
    x = ((r * s) >> 7) + 2 * o - 256;
    comp_exp = (x < 0) ? 8'h00 : (x > 255) ? 8'hff : 8'(x);
  endfunction : comp_exp

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    clk = 0;
    srst = 1;
    avs_read = 0;
    avs_write = 0;
    avs_address = 0;
    avs_writedata = 0;
    avs_byteenable = 0;
    strength_raw = 0;
    rate_dev_up = 0;
    rate_dev_down = 0;
    err_total = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rchk("reset value", ridx[i], rval[i]);
      wr(ridx[i], 8'hff);
      rchk("writable bits", ridx[i], rmsk[i]);
    end
    chk("trim all on", 32'h0000_000f, {28'h000_0000, t500, t250, t125, tsm});
    do_reset();
    for (int i = 0; i < 8; i++) begin
      rchk("value after reset", ridx[i], rval[i]);
    end
    chk("pin buffer reset", 32'h0000_0001, {31'h0000_0000, pin_en});
    wr(IDX_CRYSTAL_FINE_TRIM, 8'h05);
    bus(1'b1, IDX_CRYSTAL_FINE_TRIM, 8'h0a, 4'he, v);
    chk("trim pattern", 32'h0000_0005, {28'h000_0000, t500, t250, t125, tsm});
    wr(IDX_STRENGTH_PIN_CONFIG, 8'hfe);
    settle();
    chk("pin buffer off", 32'h0000_0000, {31'h0000_0000, pin_en});
    rchk("pin config", IDX_STRENGTH_PIN_CONFIG, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(IDX_CONVERTER_SOURCE, 8'hf8 | 8'(s));
      rchk("source select", IDX_CONVERTER_SOURCE, 8'(s));
      chk("source output", 32'(s), {29'h0000_0000, converter_source_select});
      chk("source route", {29'h0000_0000, s == 0, s == 1, s == 2},
          {29'h0000_0000, r_str, r_tmp, r_half});
    end
    for (int i = 0; i < 6; i++) begin
      wr(IDX_STRENGTH_OFFSET, c_off[i]);
      wr(IDX_STRENGTH_SLOPE, c_slp[i]);
      strength_raw <= c_raw[i];
      settle();
      chk("strength_comp", {24'h00_0000, comp_exp(c_raw[i], c_slp[i], c_off[i])},
          {24'h00_0000, strength_comp});
      rchk("strength result", IDX_STRENGTH_RESULT,
           comp_exp(c_raw[i], c_slp[i], c_off[i]));
    end
    rate_case(1'b0, 8'hff, 8'hff, 1'b1);
    rate_case(1'b1, 8'h1e, 8'h23, 1'b1);
    rate_case(1'b1, 8'h1f, 8'h23, 1'b0);
    rate_case(1'b1, 8'h1e, 8'h24, 1'b0);
    wr(IDX_RATE_UPPER, 8'h40);
    wr(IDX_RATE_LOWER, 8'h40);
    rate_case(1'b1, 8'h1f, 8'h24, 1'b1);
    rate_case(1'b1, 8'h41, 8'h24, 1'b0);
    wr(10'h3ff, 8'h5a);
    rchk("unmapped", 10'h3ff, 8'h00);
    conclude();
  end
endmodule : rxt_regs_test
